/* hdl/eba_proc.sv */
// eba_proc: processor end of external bus arbitration, priority access and flyby DMA
// assumes inputs synchronous to clk except ext DMA requests, which are synchronised here
// Summary of operation
// - master answers host request with grant
// - float address, data, strobes while granted
// - put SDRAM in self-refresh on grant
// - grant held until host drops request
// - only master drives grant; slaves monitor
// - core priority line during core access
// - master yields DMA to slave core priority
// - priority lines open drain and sensed
// - priority pull-up only on identity zero
// - DMA priority line during high-priority DMA
// - normal DMA yields to slave DMA priority
// - DMA request runs its initialised channel
// - uninitialised channel requests are ignored
// - requests arrive asynchronous to clock
// - flyby channels make flyby transactions
// - flyby strobe per flyby transaction
// - I/O output enable during flyby
// - finish outstanding transaction before grant
// - drive only own bus request line
`timescale 1ns/100ps
module eba_proc
  import eba_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  eba_if.proc bus,
  input wire logic [ID_W-1:0] processor_identity,
  input wire logic is_bus_master,
  input wire logic want_bus,
  input wire logic core_ext_access,
  input wire logic transaction_busy,
  input wire logic [NUM_DMA-1:0] chan_initialized,
  input wire logic [NUM_DMA-1:0] chan_flyby,
  input wire logic [NUM_DMA-1:0] chan_high_priority,
  output logic host_granted,
  output logic dma_active,
  output logic [1:0] dma_channel,
  output logic dma_done,
  output logic host_grant_seen,
  output logic [ID_W-1:0] id_latched
);
  eba_state_t state_reg, state_next;
  logic [NUM_DMA-1:0] sync1_reg, sync2_reg;
  logic [1:0] chan_reg, chan_next;
  logic [3:0] beat_reg, beat_next;
  logic [ID_W-1:0] id_reg;
  logic grant_reg, float_reg, refresh_reg, flyby_reg, io_device_output_enable_reg, done_reg, seen_reg;

  // double flop; only sync2 is looked at
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= bus.ext_dma_request_n;
      sync2_reg <= sync1_reg;
    end
  end

  wire [NUM_DMA-1:0] req_valid = ~sync2_reg & chan_initialized;
  wire any_req = |req_valid;
  // lowest requesting initialised channel wins
  wire [1:0] pick = req_valid[0] ? 2'h0 : req_valid[1] ? 2'h1 : req_valid[2] ? 2'h2 : 2'h3;
  wire host_wants = bus.host_request & is_bus_master;
  // peer lines as seen here, own pull masked out
  wire peer_core_pa = ~bus.core_priority_access_n & ~core_ext_access;
  wire peer_dma_pa = ~bus.dma_priority_access_n & ~(dma_active & chan_high_priority[chan_reg]);
  wire cur_high = chan_high_priority[chan_reg];
  wire must_yield = peer_core_pa | (peer_dma_pa & ~cur_high);
  wire start_blocked = peer_core_pa | (peer_dma_pa & ~chan_high_priority[pick]);
  wire last_beat = beat_reg == FLYBY_BURST_LEN - 4'h1;

  // a yield keeps chan and the next beat, so the burst resumes unless the yield passes to EBA_FINISH
  always_comb begin
    state_next = state_reg;
    chan_next = chan_reg;
    beat_next = beat_reg;
    case (state_reg)
      EBA_IDLE: begin
        if (host_wants) begin
          state_next = transaction_busy ? EBA_FINISH : EBA_GRANTED;
        end else if (any_req && is_bus_master && !start_blocked) begin
          state_next = EBA_FLYBY;
          chan_next = pick;
          beat_next = 4'h0;
        end
      end
      EBA_FINISH: begin
        if (!host_wants) begin
          state_next = EBA_IDLE;
        end else if (!transaction_busy) begin
          state_next = EBA_GRANTED;
        end
      end
      EBA_GRANTED: begin
        if (!bus.host_request) begin
          state_next = EBA_IDLE;
        end
      end
      EBA_FLYBY: begin
        if (last_beat) begin
          state_next = EBA_IDLE;
        end else begin
          beat_next = beat_reg + 4'h1;
          if (host_wants || must_yield) begin
            state_next = EBA_YIELD;
          end
        end
      end
      EBA_YIELD: begin
        if (!must_yield && !host_wants) begin
          state_next = EBA_FLYBY; // suspended transfer resumes where it stopped
        end else if (host_wants) begin
          state_next = EBA_FINISH;
        end
      end
      default: state_next = EBA_IDLE;
    endcase
  end

  wire in_grant = state_next == EBA_GRANTED;
  wire in_flyby = state_next == EBA_FLYBY;
  wire fly_mode = chan_flyby[chan_next];
  wire fly_go = in_flyby & fly_mode;
  wire end_of_burst = state_reg == EBA_FLYBY && state_next == EBA_IDLE;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= EBA_IDLE;
      chan_reg <= 2'h0;
      beat_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      chan_reg <= chan_next;
      beat_reg <= beat_next;
    end
  end

  // grant, float and self-refresh move together
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      grant_reg <= 1'b0;
      float_reg <= 1'b0;
      refresh_reg <= 1'b0;
    end else begin
      grant_reg <= in_grant;
      float_reg <= in_grant;
      refresh_reg <= in_grant;
    end
  end

  // strobe and io enable only while a flyby channel runs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flyby_reg <= 1'b0;
      io_device_output_enable_reg <= 1'b0;
    end else begin
      flyby_reg <= fly_go;
      io_device_output_enable_reg <= fly_go;
    end
  end

  // burst end pulse and a copy of the grant line
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      done_reg <= end_of_burst;
      seen_reg <= bus.host_grant;
    end
  end

  // identity taken while reset is held, constant afterwards
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      id_reg <= processor_identity;
    end
  end

  assign bus.host_grant_o = grant_reg;
  assign bus.host_grant_oe = is_bus_master;
  assign bus.bus_outputs_oe = is_bus_master & ~float_reg;
  assign bus.sdram_self_refresh = refresh_reg;
  assign bus.flyby_strobe = flyby_reg;
  assign bus.io_device_output_enable = io_device_output_enable_reg;
  assign bus.core_pa_oe = core_ext_access;
  assign bus.dma_pa_oe = dma_active & cur_high;
  assign bus.pa_pullup_en = id_reg == PULLUP_OWNER_ID;

  genvar g;
  generate
    for (g = 0; g < NUM_PROC; g++) begin : g_breq
      assign bus.bus_req_oe[g] = want_bus & (id_reg == ID_W'(g));
    end
  endgenerate

  assign host_granted = grant_reg;
  assign dma_active = state_reg == EBA_FLYBY;
  assign dma_channel = chan_reg;
  assign dma_done = done_reg;
  assign host_grant_seen = seen_reg;
  assign id_latched = id_reg;
endmodule

/* hdl/eba_pkg.sv */
// eba_pkg: shared constants for the external bus arbitration and flyby ends
// assumes one 125 MHz clock and a synchronous active-low reset
package eba_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int ID_W = 3;
  localparam int NUM_PROC = 8;
  localparam int NUM_DMA = 4;
  localparam int MSEL_W = 2;
  localparam logic [ID_W-1:0] PULLUP_OWNER_ID = 3'h0;
  localparam int PULLUP_OHMS = 500;
  // length of one flyby transfer, in bus cycles
  localparam logic [3:0] FLYBY_BURST_LEN = 4'h4;
  typedef enum logic [2:0] {
    EBA_IDLE = 3'b000,
    EBA_FINISH = 3'b001,
    EBA_GRANTED = 3'b010,
    EBA_FLYBY = 3'b011,
    EBA_YIELD = 3'b100
  } eba_state_t;
endpackage

/* hdl/eba_if.sv */
// eba_if: pins between the processor end and the host or peer end
// assumes both ends share clk; open-drain wires resolved here
`timescale 1ns/100ps
interface eba_if;
  import eba_pkg::*;
  logic host_request;
  logic host_grant_o;
  logic host_grant_oe;
  logic host_grant;
  logic core_pa_oe;
  logic dma_pa_oe;
  logic pa_pullup_en;
  logic core_priority_access_n;
  logic dma_priority_access_n;
  logic [NUM_PROC-1:0] bus_req_oe;
  logic [NUM_PROC-1:0] multiproc_bus_request_n;
  logic [NUM_DMA-1:0] ext_dma_request_n;
  logic flyby_strobe;
  logic io_device_output_enable;
  logic bus_outputs_oe;
  logic sdram_self_refresh;
  logic peer_core_pa;
  logic peer_dma_pa;
  // wired-low priority and request lines, idle high via pull-ups; undriven host_grant reads low
  assign host_grant = host_grant_oe ? host_grant_o : 1'b0;
  assign core_priority_access_n = ~(core_pa_oe | peer_core_pa);
  assign dma_priority_access_n = ~(dma_pa_oe | peer_dma_pa);
  assign multiproc_bus_request_n = ~bus_req_oe;
  modport proc (
    input host_request, host_grant, core_priority_access_n, dma_priority_access_n,
    input multiproc_bus_request_n, ext_dma_request_n,
    output host_grant_o, host_grant_oe, core_pa_oe, dma_pa_oe, pa_pullup_en, bus_req_oe,
    output flyby_strobe, io_device_output_enable, bus_outputs_oe, sdram_self_refresh
  );
  modport ext (
    output host_request, ext_dma_request_n, peer_core_pa, peer_dma_pa,
    input host_grant, flyby_strobe, io_device_output_enable, bus_outputs_oe,
    input sdram_self_refresh, core_priority_access_n, dma_priority_access_n
  );
endinterface

/* hdl/eba_ext.sv */
// eba_ext: host, peer and I/O device end of the external bus
// assumes the processor end drives grant and flyby strobes on the same clk
`timescale 1ns/100ps
module eba_ext
  import eba_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  eba_if.ext bus,
  input wire logic host_want,
  input wire logic [NUM_DMA-1:0] dev_dma_want,
  input wire logic peer_core_access,
  input wire logic peer_dma_access,
  input wire logic [DATA_W-1:0] dev_next_data,
  output logic host_owns_bus,
  output logic [DATA_W-1:0] dev_latched_data,
  output logic [7:0] flyby_count
);
  logic req_reg;
  logic [DATA_W-1:0] data_reg;
  logic [7:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      req_reg <= 1'b0;
      data_reg <= '0;
      cnt_reg <= 8'h00;
    end else begin
      // hold request for whole tenure, drop to end it
      req_reg <= host_want | (req_reg & ~bus.host_grant & host_want);
      if (bus.flyby_strobe) begin
        data_reg <= dev_next_data;
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  assign bus.host_request = req_reg;
  assign bus.ext_dma_request_n = ~dev_dma_want;
  assign bus.peer_core_pa = peer_core_access;
  assign bus.peer_dma_pa = peer_dma_access;
  assign host_owns_bus = req_reg & bus.host_grant;
  assign dev_latched_data = data_reg;
  assign flyby_count = cnt_reg;
endmodule

/* sim/eba_sva.sv */
// eba_sva: pin checks on the arbitration and flyby interface
// assumes instantiation beside the interface in the test top
`timescale 1ns/100ps
module eba_sva
  import eba_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic host_request,
  input wire logic host_grant,
  input wire logic bus_outputs_oe,
  input wire logic sdram_self_refresh,
  input wire logic flyby_strobe,
  input wire logic io_device_output_enable,
  input wire logic peer_core_pa,
  input wire logic [NUM_PROC-1:0] bus_req_oe
);
  logic [3:0] run_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_req_held; host_grant && host_request; endsequence
  sequence s_req_gone; host_grant && !host_request; endsequence
  // length of the current strobe run
  always_ff @(posedge clk) begin
    run_reg <= (!reset_n || !flyby_strobe) ? 4'h0 : run_reg + 4'h1;
  end
  chk_grant_cause: assert property ($rose(host_grant) |-> $past(host_request))
    else $error("grant without request");
  chk_grant_held: assert property (s_req_held |=> host_grant)
    else $error("grant lost while requested");
  chk_grant_release: assert property (s_req_gone |-> ##[1:2] !host_grant)
    else $error("grant kept after request dropped");
  chk_bus_floated: assert property (host_grant |-> !bus_outputs_oe && sdram_self_refresh)
    else $error("bus driven or sdram awake during grant");
  chk_flyby_io_device_output_enable: assert property (flyby_strobe |-> io_device_output_enable)
    else $error("flyby without io enable");
  chk_burst_len: assert property (run_reg <= FLYBY_BURST_LEN)
    else $error("flyby run too long");
  chk_core_yield: assert property (peer_core_pa [*3] |-> !flyby_strobe)
    else $error("flyby kept during peer core access");
  chk_own_line: assert property ($onehot0(bus_req_oe))
    else $error("several request lines driven");
endmodule

/* sim/ext_bus_arbitration_flyby_test.sv */
// ext_bus_arbitration_flyby_test: both ends joined through eba_if
// assumes a 125 MHz clock and no other agent on the bus
`timescale 1ns/100ps
module ext_bus_arbitration_flyby_test;
  import eba_pkg::*;
  typedef struct packed {logic [2:0] id; logic want; logic core; logic [7:0] req_n; logic pull; logic cpa_n;} eba_row_t;
  localparam eba_row_t rows[4] = '{'{3'h0, 1'h1, 1'h0, 8'hFE, 1'h1, 1'h1}, '{3'h5, 1'h1, 1'h1, 8'hDF, 1'h0, 1'h0},
    '{3'h7, 1'h0, 1'h1, 8'hFF, 1'h0, 1'h0}, '{3'h3, 1'h1, 1'h0, 8'hF7, 1'h0, 1'h1}};
  logic clk = 1'b0, reset_n = 1'b0, master = 1'b1, want = 1'b0, core = 1'b0, busy = 1'b0, host_want = 1'b0;
  logic peer_core = 1'b0, peer_dma = 1'b0;
  logic [3:0] hi = 4'h0, fly = 4'hF;
  logic host_granted, dma_active, host_grant_seen, host_owns_bus, d_pulse;
  logic [2:0] id_latched;
  logic [2:0] id = 3'h0;
  logic [3:0] dma_want = 4'h0, init = 4'hC;
  logic [1:0] dma_channel;
  logic [7:0] flyby_count;
  logic [63:0] latched;
  int err_total = 0, checks_done = 0, n, d;
  eba_if bus();
  eba_proc u_eba_proc (.clk(clk), .reset_n(reset_n), .bus(bus), .processor_identity(id), .is_bus_master(master),
    .want_bus(want), .core_ext_access(core), .transaction_busy(busy), .chan_initialized(init),
    .chan_flyby(fly), .chan_high_priority(hi), .host_granted(host_granted), .dma_active(dma_active),
    .dma_channel(dma_channel), .dma_done(d_pulse), .host_grant_seen(host_grant_seen), .id_latched(id_latched));
  eba_ext u_eba_ext (.clk(clk), .reset_n(reset_n), .bus(bus), .host_want(host_want), .dev_dma_want(dma_want),
    .peer_core_access(peer_core), .peer_dma_access(peer_dma), .dev_next_data(64'hA5C3_0F96_1E2D_3C4B),
    .host_owns_bus(host_owns_bus), .dev_latched_data(latched), .flyby_count(flyby_count));
  eba_sva u_eba_sva (.clk(clk), .reset_n(reset_n), .host_request(bus.host_request), .host_grant(bus.host_grant),
    .bus_outputs_oe(bus.bus_outputs_oe), .sdram_self_refresh(bus.sdram_self_refresh),
    .flyby_strobe(bus.flyby_strobe), .io_device_output_enable(bus.io_device_output_enable),
    .peer_core_pa(bus.peer_core_pa), .bus_req_oe(bus.bus_req_oe));
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    #16000;
    err_total++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  // strobe and done cycles over one burst window
  task automatic count_burst();
    n = 0;
    d = 0;
    repeat (14) begin
      @(negedge clk);
      n += (bus.flyby_strobe === 1'b1);
      d += (d_pulse === 1'b1);
    end
  endtask
  initial begin
    for (int r = 0; r < 4; r++) begin
      reset_n <= 1'b0;
      id <= rows[r].id;
      tick(12);
      reset_n <= 1'b1;
      want <= rows[r].want;
      core <= rows[r].core;
      tick(1);
      @(negedge clk);
      chk(bus.host_grant, 1'b0);
      chk(bus.flyby_strobe, 1'b0);
      chk(bus.multiproc_bus_request_n, rows[r].req_n);
      chk(bus.pa_pullup_en, rows[r].pull);
      chk(bus.core_priority_access_n, rows[r].cpa_n);
      chk(id_latched, rows[r].id);
      $display("row %0d done", r);
      tick(1);
    end
    tick(1);
    master <= 1'b0;
    host_want <= 1'b1;
    tick(6);
    @(negedge clk);
    chk(bus.host_grant, 1'b0);
    tick(1);
    master <= 1'b1;
    busy <= 1'b1;
    tick(6);
    @(negedge clk);
    chk(bus.host_grant, 1'b0);
    chk(bus.bus_outputs_oe, 1'b1);
    tick(1);
    busy <= 1'b0;
    @(negedge clk);
    chk(bus.host_grant, 1'b0);
    tick(1);
    @(negedge clk);
    chk(bus.host_grant, 1'b1);
    chk(bus.bus_outputs_oe, 1'b0);
    chk(bus.sdram_self_refresh, 1'b1);
    chk(host_granted, 1'b1);
    chk(host_owns_bus, 1'b1);
    tick(4);
    @(negedge clk);
    chk(bus.host_grant, 1'b1);
    chk(host_grant_seen, 1'b1);
    tick(1);
    host_want <= 1'b0;
    tick(3);
    @(negedge clk);
    chk(bus.host_grant, 1'b0);
    chk(bus.bus_outputs_oe, 1'b1);
    chk(bus.sdram_self_refresh, 1'b0);
    $display("host test done");
    tick(1);
    dma_want <= 4'h1;
    tick(8);
    @(negedge clk);
    chk(bus.flyby_strobe, 1'b0);
    chk(dma_active, 1'b0);
    tick(1);
    dma_want <= 4'h5;
    tick(1);
    dma_want <= 4'h0;
    count_burst();
    chk(n, 4);
    chk(d, 1);
    chk(dma_channel, 2'h2);
    chk(flyby_count, 8'h04);
    chk(latched, 64'hA5C3_0F96_1E2D_3C4B);
    $display("flyby test done");
    tick(1);
    peer_core <= 1'b1;
    dma_want <= 4'h8;
    tick(8);
    @(negedge clk);
    chk(bus.flyby_strobe, 1'b0);
    tick(1);
    peer_core <= 1'b0;
    dma_want <= 4'h0;
    count_burst();
    chk(n, 4);
    chk(flyby_count, 8'h08);
    $display("yield test done");
    tick(1);
    dma_want <= 4'h8;
    tick(1);
    dma_want <= 4'h0;
    tick(3);
    peer_core <= 1'b1;
    @(negedge clk);
    chk(bus.flyby_strobe, 1'b1);
    chk(bus.io_device_output_enable, 1'b1);
    chk(dma_active, 1'b1);
    tick(1);
    @(negedge clk);
    chk(bus.flyby_strobe, 1'b0);
    chk(dma_active, 1'b0);
    tick(2);
    peer_core <= 1'b0;
    tick(8);
    @(negedge clk);
    chk(flyby_count, 8'h0C);
    chk(dma_channel, 2'h3);
    $display("suspend test done");
    tick(1);
    peer_dma <= 1'b1;
    hi <= 4'h8;
    dma_want <= 4'h4;
    tick(8);
    @(negedge clk);
    chk(bus.flyby_strobe, 1'b0);
    chk(bus.dma_priority_access_n, 1'b0);
    tick(1);
    dma_want <= 4'h8;
    tick(1);
    dma_want <= 4'h0;
    tick(2);
    @(negedge clk);
    chk(bus.flyby_strobe, 1'b1);
    chk(bus.dma_pa_oe, 1'b1);
    tick(4);
    @(negedge clk);
    chk(flyby_count, 8'h10);
    chk(bus.dma_pa_oe, 1'b0);
    tick(1);
    peer_dma <= 1'b0;
    fly <= 4'h7;
    dma_want <= 4'h8;
    tick(1);
    dma_want <= 4'h0;
    tick(2);
    @(negedge clk);
    chk(dma_active, 1'b1);
    chk(bus.flyby_strobe, 1'b0);
    chk(bus.io_device_output_enable, 1'b0);
    chk(bus.dma_priority_access_n, 1'b0);
    tick(4);
    @(negedge clk);
    chk(bus.dma_priority_access_n, 1'b1);
    chk(d_pulse, 1'b1);
    chk(flyby_count, 8'h10);
    $display("priority test done");
    report_and_stop();
  end
endmodule
